// ### core/anrx_pkg.sv
// Constants for the received next-page status register block.
// Assumes a 32-bit APB slave on a single 20 MHz clock domain.
package anrx_pkg;

  // APB geometry.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 16;

  // Printed register index and the byte address derived from it.
  localparam logic [ADDR_W-1:0] RXNP_IDX  = 12'h00EA;
  localparam logic [ADDR_W-1:0] RXNP_ADDR = 12'(RXNP_IDX * 4);
  // Local control and status registers.
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h0400;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h0404;

  // Field positions of the link code word.
  localparam int unsigned NP_BIT     = 15;
  localparam int unsigned ACK_BIT    = 14;
  localparam int unsigned MP_BIT     = 13;
  localparam int unsigned CC_BIT     = 12;
  localparam int unsigned TOG_BIT    = 11;
  localparam int unsigned CODE_MSB   = 10;
  localparam int unsigned CODE_LSB   = 0;

  // Control register fields.
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CHK_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h3;

  // Status register fields.
  localparam int unsigned STAT_TERR_BIT = 0;
  localparam int unsigned STAT_LAST_BIT = 1;
  localparam int unsigned STAT_CNT_LSB  = 8;
  localparam int unsigned CNT_W         = 8;

  // Reset values.
  localparam logic [WORD_W-1:0] RXNP_RESET = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_RESET  = 8'h00;

  // Consecutive consistent bursts needed before a word is trusted.
  localparam logic [1:0] MATCH_NEED = 2'h3;
  localparam logic [1:0] MATCH_ONE  = 2'h1;
  localparam logic [1:0] MATCH_ZERO = 2'h0;

  // Register selector returned by the address decoder.
  typedef enum logic [1:0] {
    ANRX_SEL_NONE = 2'b00,
    ANRX_SEL_RXNP = 2'b01,
    ANRX_SEL_CTRL = 2'b11,
    ANRX_SEL_STAT = 2'b10
  } anrx_sel_t;

  // Exchange progress, Gray coded along the usual path.
  typedef enum logic [1:0] {
    ANRX_WAIT_BASE = 2'b00,
    ANRX_NEXT      = 2'b01,
    ANRX_DONE      = 2'b11
  } anrx_state_t;

endpackage

// ### core/anrx_match_if.sv
// Carrier between the top block and the burst consistency checker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface anrx_match_if;
  logic                           ce;
  logic                           clear;
  logic                           valid;
  logic [anrx_pkg::WORD_W-1:0]    word;
  logic [1:0]                     count;
  logic                           hit;

  modport top (output ce, clear, valid, word, input count, hit);
  modport chk (input ce, clear, valid, word, output count, hit);
endinterface
`default_nettype wire

// ### core/anrx_match.sv
// Counts consecutive received bursts that agree apart from the acknowledge bit.
// Assumes word strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module anrx_match (
  // Clock and reset
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  // Checker side of the carrier
  anrx_match_if.chk   m
);

  logic [anrx_pkg::WORD_W-1:0] prev;
  logic [anrx_pkg::WORD_W-1:0] next_prev;
  logic [1:0]                  count;
  logic [1:0]                  next_count;
  logic [anrx_pkg::WORD_W-1:0] mask;
  logic                        same;

  // The acknowledge bit is ignored when comparing bursts.
  always_comb begin
    mask       = ~(16'h0001 << anrx_pkg::ACK_BIT);
    same       = ((m.word & mask) == (prev & mask)) && (count != anrx_pkg::MATCH_ZERO);
    next_prev  = prev;
    next_count = count;
    m.hit      = 1'b0;
    if (m.clear) begin
      next_count = anrx_pkg::MATCH_ZERO;
    end else if (m.valid) begin
      next_prev = m.word;
      if (!same) begin
        next_count = anrx_pkg::MATCH_ONE;
      end else if (count != anrx_pkg::MATCH_NEED) begin
        next_count = count + 2'h1;
        m.hit      = (count + 2'h1) == anrx_pkg::MATCH_NEED;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev  <= anrx_pkg::RXNP_RESET;
      count <= anrx_pkg::MATCH_ZERO;
    end else if (m.ce) begin
      prev  <= next_prev;
      count <= next_count;
    end
  end

  assign m.count = count;

endmodule // anrx_match
`default_nettype wire

// ### core/anrx_rx_np_top.sv
// Received next-page status register with its APB slave and page acceptance.
// Assumes the arbitration logic strobes decoded words on the same clock.
`timescale 1ns/1ps
`default_nettype none
module anrx_rx_np_top (
  // Clock, reset and clock enable
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // APB slave
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [anrx_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [anrx_pkg::DATA_W-1:0]   pwdata_i,
  output logic      [anrx_pkg::DATA_W-1:0]   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  // Arbitration side
  input  wire logic                          restart_i,
  input  wire logic                          base_valid_i,
  input  wire logic [anrx_pkg::WORD_W-1:0]   base_word_i,
  input  wire logic                          page_valid_i,
  input  wire logic [anrx_pkg::WORD_W-1:0]   page_word_i,
  output logic                               ack_o,
  output logic                               page_taken_o
);

  function automatic anrx_pkg::anrx_sel_t decode(input logic [anrx_pkg::ADDR_W-1:0] a);
    anrx_pkg::anrx_sel_t s;
    s = anrx_pkg::ANRX_SEL_NONE;
    if (a == anrx_pkg::RXNP_ADDR) s = anrx_pkg::ANRX_SEL_RXNP;
    if (a == anrx_pkg::CTRL_ADDR) s = anrx_pkg::ANRX_SEL_CTRL;
    if (a == anrx_pkg::STAT_ADDR) s = anrx_pkg::ANRX_SEL_STAT;
    return s;
  endfunction

  anrx_match_if mi ();

  anrx_match u_match (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .m         (mi.chk)
  );

  // Page exchange state.
  anrx_pkg::anrx_state_t       state;
  anrx_pkg::anrx_state_t       next_state;
  logic [anrx_pkg::WORD_W-1:0] rxnp;
  logic [anrx_pkg::WORD_W-1:0] next_rxnp;
  logic                        last_tog;
  logic                        next_last_tog;
  logic                        ack;
  logic                        next_ack;
  logic                        taken;
  logic                        next_taken;
  logic                        tog_ok;
  logic                        accept;
  logic                        hit_np;

  // Software state.
  logic [1:0]                  ctrl;
  logic [1:0]                  next_ctrl;
  logic                        terr;
  logic                        next_terr;
  logic                        last_seen;
  logic                        next_last_seen;
  logic [anrx_pkg::CNT_W-1:0]  pg_cnt;
  logic [anrx_pkg::CNT_W-1:0]  next_pg_cnt;

  // Bus state.
  logic [anrx_pkg::DATA_W-1:0] rdata;
  logic [anrx_pkg::DATA_W-1:0] next_rdata;
  logic                        rdy;
  logic                        next_rdy;
  logic                        err;
  logic                        next_err;
  logic                        wr_done;
  anrx_pkg::anrx_sel_t         sel;

  assign mi.ce    = ce_i;
  assign mi.clear = restart_i;
  assign mi.valid = page_valid_i && (state == anrx_pkg::ANRX_NEXT);
  assign mi.word  = page_word_i;

  // A next page is taken once three consistent bursts agree and, with the toggle check on, its toggle fits.
  always_comb begin
    hit_np         = mi.hit && ctrl[anrx_pkg::CTRL_EN_BIT] && !restart_i;
    tog_ok         = page_word_i[anrx_pkg::TOG_BIT] == ~last_tog;
    accept         = hit_np && (tog_ok || !ctrl[anrx_pkg::CTRL_CHK_BIT]);
    next_state     = state;
    next_rxnp      = rxnp;
    next_last_tog  = last_tog;
    next_ack       = ack;
    next_taken     = 1'b0;
    if (restart_i) begin
      next_state = anrx_pkg::ANRX_WAIT_BASE;
      next_ack   = 1'b0;
    end else begin
      unique case (state)
        anrx_pkg::ANRX_WAIT_BASE: begin
          if (base_valid_i) begin
            next_last_tog = base_word_i[anrx_pkg::TOG_BIT];
            next_state    = anrx_pkg::ANRX_NEXT;
          end
        end
        anrx_pkg::ANRX_NEXT: begin
          if (hit_np) begin
            next_ack = 1'b1;
          end
          if (accept) begin
            next_rxnp     = page_word_i;
            next_last_tog = page_word_i[anrx_pkg::TOG_BIT];
            next_taken    = 1'b1;
            if (!page_word_i[anrx_pkg::NP_BIT]) begin
              next_state = anrx_pkg::ANRX_DONE;
            end
          end
        end
        anrx_pkg::ANRX_DONE: begin
          next_state = anrx_pkg::ANRX_DONE;
        end
        default: begin
          next_state = anrx_pkg::ANRX_WAIT_BASE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state    <= anrx_pkg::ANRX_WAIT_BASE;
      rxnp     <= anrx_pkg::RXNP_RESET;
      last_tog <= 1'b0;
      ack      <= 1'b0;
      taken    <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      rxnp     <= next_rxnp;
      last_tog <= next_last_tog;
      ack      <= next_ack;
      taken    <= next_taken;
    end
  end

  // APB: answer in the second access cycle; writes land on the completing edge.
  always_comb begin
    sel        = decode(paddr_i);
    wr_done    = psel_i && penable_i && rdy && pwrite_i;
    next_rdy   = psel_i && penable_i && !rdy;
    next_err   = psel_i && penable_i && !rdy && (sel == anrx_pkg::ANRX_SEL_NONE);
    next_rdata = rdata;
    if (psel_i && penable_i && !rdy) begin
      next_rdata = '0;
      if (!pwrite_i) begin
        unique case (sel)
          anrx_pkg::ANRX_SEL_RXNP: next_rdata[anrx_pkg::WORD_W-1:0] = rxnp;
          anrx_pkg::ANRX_SEL_CTRL: next_rdata[anrx_pkg::CTRL_CHK_BIT:anrx_pkg::CTRL_EN_BIT] = ctrl;
          anrx_pkg::ANRX_SEL_STAT: begin
            next_rdata[anrx_pkg::STAT_TERR_BIT] = terr;
            next_rdata[anrx_pkg::STAT_LAST_BIT] = last_seen;
            next_rdata[anrx_pkg::STAT_CNT_LSB +: anrx_pkg::CNT_W] = pg_cnt;
          end
          anrx_pkg::ANRX_SEL_NONE: next_rdata = '0;
        endcase
      end
    end
  end

  always_comb begin
    next_ctrl      = ctrl;
    next_terr      = terr;
    next_last_seen = last_seen;
    next_pg_cnt    = pg_cnt;
    if (wr_done && sel == anrx_pkg::ANRX_SEL_CTRL) begin
      next_ctrl = pwdata_i[anrx_pkg::CTRL_CHK_BIT:anrx_pkg::CTRL_EN_BIT];
    end
    if (wr_done && sel == anrx_pkg::ANRX_SEL_STAT) begin
      if (pwdata_i[anrx_pkg::STAT_TERR_BIT]) next_terr = 1'b0;
      if (pwdata_i[anrx_pkg::STAT_LAST_BIT]) next_last_seen = 1'b0;
    end
    // Hardware events win over a clear in the same cycle.
    if (hit_np && !tog_ok && ctrl[anrx_pkg::CTRL_CHK_BIT]) begin
      next_terr = 1'b1;
    end
    if (accept) begin
      next_pg_cnt = pg_cnt + 8'h01;
      if (!page_word_i[anrx_pkg::NP_BIT]) next_last_seen = 1'b1;
    end
    if (restart_i) begin
      next_pg_cnt = anrx_pkg::CNT_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata     <= '0;
      rdy       <= 1'b0;
      err       <= 1'b0;
      ctrl      <= anrx_pkg::CTRL_RESET;
      terr      <= 1'b0;
      last_seen <= 1'b0;
      pg_cnt    <= anrx_pkg::CNT_RESET;
    end else if (ce_i) begin
      rdata     <= next_rdata;
      rdy       <= next_rdy;
      err       <= next_err;
      ctrl      <= next_ctrl;
      terr      <= next_terr;
      last_seen <= next_last_seen;
      pg_cnt    <= next_pg_cnt;
    end
  end

  assign prdata_o     = rdata;
  assign pready_o     = rdy;
  assign pslverr_o    = err;
  assign ack_o        = ack;
  assign page_taken_o = taken;

  // Checks.
  property p_update;
    @(posedge sys_clk_i) disable iff (rst_i)
      (accept && ce_i) |=> (rxnp == $past(page_word_i)) && taken;
  endproperty
  AST_RXNP_UPDATE: assert property (p_update)
    else $error("Register did not take the accepted page whole.");

  // Read data was loaded from the register on the edge that raised ready.
  AST_ACK_POSITION: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rdy && !$past(rdy) && !pwrite_i && sel == anrx_pkg::ANRX_SEL_RXNP && !err)
      |-> (rdata[anrx_pkg::ACK_BIT] == $past(rxnp[anrx_pkg::ACK_BIT])))
    else $error("Acknowledge bit read back from the wrong position.");

  AST_ACK_THREE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(ack) |-> (mi.count == anrx_pkg::MATCH_NEED))
    else $error("Acknowledge raised before three consistent bursts.");

  AST_TOGGLE_FIRST: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state == anrx_pkg::ANRX_WAIT_BASE && base_valid_i && ce_i && !restart_i)
      |=> (last_tog == $past(base_word_i[anrx_pkg::TOG_BIT])))
    else $error("First expected toggle not tied to base word.");

  AST_TOGGLE_ALT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && ctrl[anrx_pkg::CTRL_CHK_BIT])
      |-> (page_word_i[anrx_pkg::TOG_BIT] != last_tog))
    else $error("Page accepted with a repeated toggle.");

  AST_RESET_ZERO: assert property (@(posedge sys_clk_i)
    rst_i |=> (rxnp == anrx_pkg::RXNP_RESET) && !rdy && !ack)
    else $error("Register not zero after reset.");

  AST_PREADY_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
    rdy |=> !rdy)
    else $error("Ready held longer than one cycle.");

  AST_RO_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (wr_done && sel == anrx_pkg::ANRX_SEL_RXNP && !accept) |=> $stable(rxnp))
    else $error("Write changed the read-only register.");

  AST_LAST_PAGE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (accept && ce_i && !page_word_i[anrx_pkg::NP_BIT]) |=> (state == anrx_pkg::ANRX_DONE))
    else $error("Last page did not end the exchange.");

  AST_ACK_RESTART: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (restart_i && ce_i) |=> !ack)
    else $error("Acknowledge survived a restart.");

  AST_TERR_SET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (hit_np && !tog_ok && ctrl[anrx_pkg::CTRL_CHK_BIT] && ce_i) |=> (terr && !taken))
    else $error("Refused toggle did not raise the error flag.");

  AST_UNMAPPED_ERR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (psel_i && penable_i && !rdy && ce_i && sel == anrx_pkg::ANRX_SEL_NONE) |=> (rdy && err))
    else $error("Unmapped access answered without an error.");

  AST_TAKEN_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
    taken |=> !taken)
    else $error("Page taken strobe held longer than one cycle.");

  COV_ACCEPT: cover property (@(posedge sys_clk_i) disable iff (rst_i) accept);
  COV_TERR:   cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(terr));
  COV_DONE:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
    state == anrx_pkg::ANRX_DONE);
  COV_READ:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
    rdy && sel == anrx_pkg::ANRX_SEL_RXNP && !pwrite_i);
  COV_NO_CHECK: cover property (@(posedge sys_clk_i) disable iff (rst_i) accept && !tog_ok);

endmodule // anrx_rx_np_top
`default_nettype wire

// ### testbench/anrx_partner.sv
// Remote link partner model: sends a base word, then next pages as bursts.
// Assumes the block samples words on the rising edge of the same clock.
`timescale 1ns/1ps
`default_nettype none
module anrx_partner (
  // Clock
  input  wire logic                    sys_clk_i,
  // Link side towards the block
  output logic                         base_valid_o,
  output logic [anrx_pkg::WORD_W-1:0]  base_word_o,
  output logic                         page_valid_o,
  output logic [anrx_pkg::WORD_W-1:0]  page_word_o
);
  logic last_tog;

  initial begin
    base_valid_o = 1'b0;
    base_word_o  = 16'h0000;
    page_valid_o = 1'b0;
    page_word_o  = 16'h0000;
    last_tog     = 1'b0;
  end

  task automatic send_base(input logic [15:0] w);
    @(posedge sys_clk_i);
    base_valid_o <= 1'b1;
    base_word_o  <= w;
    @(posedge sys_clk_i);
    base_valid_o <= 1'b0;
    base_word_o  <= ~w;
    last_tog = w[11];
  endtask

  // The acknowledge bit is set from the second burst on, as a real partner does.
  task automatic send_page(input logic np, input logic mp, input logic cc,
                           input logic [10:0] code, input int bursts,
                           input logic bad_tog, output logic [15:0] w);
    logic tog;
    tog = ~last_tog ^ bad_tog;
    w = {np, 1'b0, mp, cc, tog, code};
    for (int i = 0; i < bursts; i++) begin
      @(posedge sys_clk_i);
      w[14] = (i > 0);
      page_valid_o <= 1'b1;
      page_word_o  <= w;
    end
    @(posedge sys_clk_i);
    page_valid_o <= 1'b0;
    page_word_o  <= ~w;
    if (!bad_tog && bursts >= 3)
      last_tog = tog;
  endtask
endmodule // anrx_partner
`default_nettype wire

// ### testbench/tb_autoneg_rx_next_page_reg.sv
// Self-checking bench for the received next-page register block.
// Assumes anrx_pkg, the design files and anrx_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_rx_next_page_reg;
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        ce_i      = 1'b1;
  logic        restart_i = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [11:0] paddr_i   = 12'h000;
  logic [31:0] pwdata_i  = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        ack_o;
  logic        page_taken_o;
  logic        base_valid;
  logic        page_valid;
  logic [15:0] base_word;
  logic [15:0] page_word;
  logic [15:0] last_w;
  logic [31:0] rd;
  logic        er;
  logic [15:0] w;
  int          err_total = 0;
  int          compares  = 0;
  int          taken     = 0;
  int          n0;

  always #25 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) if (page_taken_o === 1'b1) taken <= taken + 1;

  anrx_rx_np_top u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .restart_i(restart_i), .base_valid_i(base_valid), .base_word_i(base_word),
    .page_valid_i(page_valid), .page_word_i(page_word), .ack_o(ack_o),
    .page_taken_o(page_taken_o));

  anrx_partner u_partner (.sys_clk_i(sys_clk_i), .base_valid_o(base_valid),
    .base_word_o(base_word), .page_valid_o(page_valid), .page_word_o(page_word));

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      wrap_up();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic restart();
    @(posedge sys_clk_i);
    restart_i <= 1'b1;
    @(posedge sys_clk_i);
    restart_i <= 1'b0;
  endtask

  task automatic page(input logic np, mp, cc, input logic [10:0] c, input int b, input logic bad);
    n0 = taken;
    u_partner.send_page(np, mp, cc, c, b, bad, w);
    repeat (3) @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
    chk("rxnp reset", 32'h0000_0000, rd);
    apb(1'b0, anrx_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl reset", 32'h0000_0003, rd);
  endtask

  task automatic t_exchange();
    logic [10:0] codes[3] = '{11'h5A5, 11'h7FF, 11'h001};
    logic [2:0]  mps = 3'b101;
    logic [2:0]  ccs = 3'b110;
    restart();
    u_partner.send_base(16'h0800);
    for (int i = 0; i < 3; i++) begin
      page(i < 2, mps[i], ccs[i], codes[i], 3, 1'b0);
      chk("taken", n0 + 1, taken);
      chk("ack", 32'h1, {31'h0, ack_o});
      apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
      chk("rxnp", {16'h0, w}, rd);
      chk("toggle", 32'(i % 2), {31'h0, rd[11]});
    end
    page(1'b1, 1'b0, 1'b0, 11'h123, 3, 1'b0);
    chk("taken after last", n0, taken);
    apb(1'b0, anrx_pkg::STAT_ADDR, 32'h0);
    chk("stat", 32'h0000_0302, rd & 32'h0000_FF03);
  endtask

  task automatic t_short();
    restart();
    repeat (2) @(posedge sys_clk_i);
    chk("ack cleared", 32'h0, {31'h0, ack_o});
    u_partner.send_base(16'h0000);
    page(1'b1, 1'b1, 1'b1, 11'h2AA, 2, 1'b0);
    chk("ack two bursts", 32'h0, {31'h0, ack_o});
    chk("taken two bursts", n0, taken);
    page(1'b1, 1'b0, 1'b0, 11'h0F0, 3, 1'b0);
    last_w = w;
    apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
    chk("rxnp", {16'h0, last_w}, rd);
    chk("toggle", 32'h1, {31'h0, rd[11]});
  endtask

  task automatic t_bad_tog();
    page(1'b1, 1'b1, 1'b0, 11'h444, 3, 1'b1);
    chk("taken bad toggle", n0, taken);
    apb(1'b0, anrx_pkg::STAT_ADDR, 32'h0);
    chk("toggle error", 32'h1, {31'h0, rd[0]});
    apb(1'b1, anrx_pkg::STAT_ADDR, 32'h0000_0001);
    apb(1'b0, anrx_pkg::STAT_ADDR, 32'h0);
    chk("toggle error cleared", 32'h0, {31'h0, rd[0]});
  endtask

  task automatic t_apb_misc();
    apb(1'b1, anrx_pkg::RXNP_ADDR, 32'hFFFF_FFFF);
    chk("rxnp write err", 32'h0, {31'h0, er});
    apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
    chk("rxnp after write", {16'h0, last_w}, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_ctrl_modes();
    apb(1'b1, anrx_pkg::CTRL_ADDR, 32'h0000_0000);
    apb(1'b0, anrx_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl written", 32'h0000_0000, rd);
    page(1'b1, 1'b0, 1'b1, 11'h3C3, 3, 1'b0);
    chk("taken disabled", n0, taken);
    // The partner counts the refused page as sent, so its next toggle repeats.
    apb(1'b1, anrx_pkg::CTRL_ADDR, 32'h0000_0001);
    page(1'b1, 1'b1, 1'b1, 11'h1E1, 3, 1'b0);
    chk("taken no check", n0 + 1, taken);
    apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
    chk("rxnp no check", {16'h0, w}, rd);
    apb(1'b0, anrx_pkg::STAT_ADDR, 32'h0);
    chk("no toggle error", 32'h0, {31'h0, rd[0]});
    apb(1'b1, anrx_pkg::CTRL_ADDR, 32'h0000_0003);
  endtask

  task automatic t_freeze_reset();
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    restart();
    @(posedge sys_clk_i);
    chk("ack frozen", 32'h1, {31'h0, ack_o});
    ce_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    chk("ack after reset", 32'h0, {31'h0, ack_o});
    apb(1'b0, anrx_pkg::RXNP_ADDR, 32'h0);
    chk("rxnp after reset", 32'h0000_0000, rd);
    apb(1'b0, anrx_pkg::CTRL_ADDR, 32'h0);
    chk("ctrl after reset", 32'h0000_0003, rd);
    apb(1'b0, anrx_pkg::STAT_ADDR, 32'h0);
    chk("stat after reset", 32'h0000_0000, rd);
  endtask

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_exchange();
    t_short();
    t_bad_tog();
    t_apb_misc();
    t_ctrl_modes();
    t_freeze_reset();
    wrap_up();
  end
endmodule // tb_autoneg_rx_next_page_reg
`default_nettype wire
